// File: sim/dco_board.sv
// board-side pll model: lock follows pll_run after a delay
`default_nettype none
module dco_board #(
	parameter int LOCK_DLY = 8
) (
	// clock and reset
	input  wire logic hclk,
	input  wire logic hresetn,
	// pll
	input  wire logic pll_run,
	output logic      pll_locked
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt_r;
	// lock is lost at once when the pll stops, so a restart must relock
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 0;
			pll_locked <= 1'b0;
		end else if (!pll_run) begin
			cnt_r <= 0;
			pll_locked <= 1'b0;
		end else if (cnt_r < LOCK_DLY) begin
			cnt_r <= cnt_r + 1;
		end else begin
			pll_locked <= 1'b1;
		end
	end
endmodule : dco_board
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the gated clock output block
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s exp %0h got %0h", nm, e, g); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import dco_pkg::*;
	// output clock period in hclk cycles at the reset divider
	localparam int PER = 2 * (DCO_DIV_RESET + 1);
	logic hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp, power_good_down;
	logic pll_locked, pll_run, feedback_clock_out;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [11:0] oe_n;
	dco_diff_t   diff_clock_out;
	int fails, samples_checked, ed, f, l, i;

	dco_top dut_u (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.hwrite(hwrite), .htrans(htrans), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.oe_n(oe_n), .power_good_down(power_good_down), .pll_locked(pll_locked),
		.pll_run(pll_run), .diff_clock_out(diff_clock_out),
		.feedback_clock_out(feedback_clock_out));
	dco_board board_u (.hclk(hclk), .hresetn(hresetn), .pll_run(pll_run),
		.pll_locked(pll_locked));

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	task complete_run;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			fails++;
			complete_run();
		end
	endtask : wait_ready

	// one single word transfer; read data taken at the data phase edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= DCO_HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		hsize <= DCO_HSIZE_WORD;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		`CHK("hresp", 1'b0, hresp)
	endtask : ahb

	// rising edges, first rise and last active sample of one output
	task automatic measure(input int k, input int n, output int e, output int fr,
		output int la);
		logic pv;
		e = 0;
		fr = 0;
		la = 0;
		pv = diff_clock_out.p[k];
		for (int j = 1; j <= n; j++) begin
			// mid-cycle, where the registered outputs have settled
			@(negedge hclk);
			if (diff_clock_out.p[k] === 1'b1 && pv !== 1'b1) begin
				e++;
				if (fr == 0) fr = j;
			end
			if ((diff_clock_out.p[k] | diff_clock_out.n[k]) !== 1'b0) la = j;
			pv = diff_clock_out.p[k];
		end
	endtask : measure

	always @(negedge hclk) if (hresetn === 1'b1)
		`CHK("legs_overlap", 12'h000, diff_clock_out.p & diff_clock_out.n)

	initial begin
		hresetn = 1'b0;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h0;
		hwdata = 32'h0;
		oe_n = 12'hfff;
		power_good_down = 1'b0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		measure(0, 40, ed, f, l);
		`CHK("off_unpowered", 0, l)
		ahb(1'b0, DCO_ADDR_OE, 32'h0, q);
		`CHK("oe_reset", DCO_OE_RESET, q[11:0])
		ahb(1'b0, DCO_ADDR_DIV, 32'h0, q);
		`CHK("div_reset", DCO_DIV_RESET, q[7:0])
		ahb(1'b0, 8'h0c, 32'h0, q);
		`CHK("unmapped", 32'h0, q)
		ahb(1'b1, DCO_ADDR_DIV, 32'h00000003, q);
		ahb(1'b0, DCO_ADDR_DIV, 32'h0, q);
		`CHK("div_write", 8'h03, q[7:0])
		ahb(1'b1, DCO_ADDR_DIV, 32'(DCO_DIV_RESET), q);
		@(posedge hclk);
		power_good_down <= 1'b1;
		i = 0;
		while (pll_locked !== 1'b1 && i < 200) begin
			@(posedge hclk);
			i++;
		end
		if (i >= 200) begin
			fails++;
			complete_run();
		end
		measure(3, 60, ed, f, l);
		`CHK("pin_high_off", 0, l)
		@(posedge hclk);
		oe_n <= 12'h000;
		measure(3, 60, ed, f, l);
		`CHK("on_latency", 1'b1, (f >= DCO_ON_MIN_PER * PER && f <= DCO_ON_MAX_PER * PER))
		for (int k = 0; k < 12; k++) begin
			measure(k, 12, ed, f, l);
			`CHK("each_runs", 1'b1, (ed >= 1))
		end
		ahb(1'b0, DCO_ADDR_STATUS, 32'h0, q);
		`CHK("run_status", 32'(1 << DCO_ST_LOCK_BIT) | 32'h00000fff, q)
		@(posedge hclk);
		oe_n[3] <= 1'b1;
		measure(3, 80, ed, f, l);
		`CHK("off_keep", 1'b1, (ed >= DCO_OFF_KEEP_PER))
		`CHK("off_latency", 1'b1, (l <= DCO_OFF_MAX_PER * PER))
		@(posedge hclk);
		oe_n[3] <= 1'b0;
		measure(3, 60, ed, f, l);
		`CHK("pin_restart", 1'b1, (ed >= 1))
		ahb(1'b1, DCO_ADDR_OE, 32'h00000ff7, q);
		measure(3, 80, ed, f, l);
		`CHK("bit_off", 1'b1, (l <= DCO_OFF_MAX_PER * PER))
		measure(4, 12, ed, f, l);
		`CHK("other_runs", 1'b1, (ed >= 1))
		ahb(1'b0, DCO_ADDR_OE, 32'h0, q);
		`CHK("oe_readback", 12'hff7, q[11:0])
		ahb(1'b1, DCO_ADDR_OE, 32'h00000fff, q);
		measure(3, 60, ed, f, l);
		@(posedge hclk);
		power_good_down <= 1'b0;
		measure(3, 24, ed, f, l);
		`CHK("pd_latency", 1'b1, (l <= (DCO_PD_SAMPLES + 2) * PER))
		`CHK("pll_stopped", 1'b0, pll_run)
		`CHK("fb_stopped", 1'b0, feedback_clock_out)
		ahb(1'b0, DCO_ADDR_STATUS, 32'h0, q);
		`CHK("pd_status", 1'b1, q[DCO_ST_PD_BIT])
		complete_run();
	end
endmodule : testbench
`default_nettype wire

// File: src/dco_pkg.sv
// package for the differential clock output enable block
`default_nettype none
package dco_pkg;
	localparam int          DCO_NUM_OUT      = 12;
	localparam int          DCO_SYNC_STAGES  = 2;
	// output-clock periods of the enable window
	localparam int          DCO_ON_MIN_PER   = 4;
	localparam int          DCO_ON_MAX_PER   = 12;
	localparam int          DCO_OFF_KEEP_PER = 4;
	localparam int          DCO_OFF_MAX_PER  = 12;
	localparam int          DCO_PD_SAMPLES   = 2;
	// register map
	localparam logic [7:0]  DCO_ADDR_OE      = 8'h00;
	localparam logic [7:0]  DCO_ADDR_STATUS  = 8'h04;
	localparam logic [7:0]  DCO_ADDR_DIV     = 8'h08;
	localparam logic [11:0] DCO_OE_RESET     = 12'hfff;
	localparam logic [7:0]  DCO_DIV_RESET    = 8'h01;
	localparam logic [1:0]  DCO_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0]  DCO_HTRANS_SEQ    = 2'h3;
	localparam logic [2:0]  DCO_HSIZE_WORD    = 3'h2;
	localparam int          DCO_ST_LOCK_BIT   = 12;
	localparam int          DCO_ST_PD_BIT     = 13;

	typedef enum logic [1:0] {
		DCO_CH_OFF,
		DCO_CH_WAIT_ON,
		DCO_CH_ON,
		DCO_CH_DRAIN
	} dco_ch_state_t;

	typedef struct packed {
		logic [11:0] p;
		logic [11:0] n;
	} dco_diff_t;

	typedef struct packed {
		logic        sel;
		logic [31:0] addr;
		logic        write;
		logic [1:0]  trans;
		logic [2:0]  size;
		logic [31:0] wdata;
	} dco_ahb_req_t;
endpackage : dco_pkg
`default_nettype wire

// File: src/dco_sync.sv
// two-flop synchroniser bank for the enable and power pins
`default_nettype none
module dco_sync #(
	parameter int               WIDTH   = 12,
	// reset level per bit: each pin's idle level, so release makes no false edge
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	// clock and reset
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             ce,
	// data
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s1_nxt;
	logic [WIDTH-1:0] s2_nxt;

	always_comb begin
		s1_nxt = ce ? din : s1_r;
		s2_nxt = ce ? s1_r : dout;
	end

	// only the second stage is read outside, the first may go metastable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			s1_r <= s1_nxt;
			dout <= s2_nxt;
		end
	end
endmodule : dco_sync
`default_nettype wire

// File: src/dco_top.sv
// gated twelve-output differential clock buffer with ahb-lite control
//
// Contract
// - each output has own register enable bit
// - twelve outputs, each with own pin
// - enable pin requests output when low
// - register enables active high, reset set
// - disabled output drives both legs low
// - run only when bit 1 and pin 0
// - pin 0 runs clock, pin 1 low/low
// - pin falling restarts output without glitch
// - output active 4 to 12 periods
// - pin rising stops output without glitch
// - at least four full clocks after deassert
// - disabled within 12 periods of deassert
// - no clocks before power-good and lock
// - power-down forces low/low before pll stops
// - power-down acts after two rising samples
//
// Local design decisions: the register addresses and the AHB-Lite slave port.
`default_nettype none
module dco_top #(
	parameter int NOUT = dco_pkg::DCO_NUM_OUT
) (
	// clock, reset, enable
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                ce,
	// ahb-lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic                hwrite,
	input  wire logic [1:0]          htrans,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	// pins
	input  wire logic [NOUT-1:0]     oe_n,
	input  wire logic                power_good_down,
	input  wire logic                pll_locked,
	output logic                     pll_run,
	// clock outputs
	output dco_pkg::dco_diff_t       diff_clock_out,
	output logic                     feedback_clock_out
);
	import dco_pkg::*;

	// saturating step, a stuck state never wraps its counter
	function automatic logic [3:0] cnt_inc(input logic [3:0] c);
		cnt_inc = (c == 4'hf) ? c : c + 4'h1;
	endfunction : cnt_inc

	// bus state
	logic [NOUT-1:0] oe_reg_r;
	logic [NOUT-1:0] oe_reg_nxt;
	logic [7:0]      div_r;
	logic [7:0]      div_nxt;
	logic            wr_pend_r;
	logic            wr_pend_nxt;
	logic [7:0]      wr_addr_r;
	logic [7:0]      wr_addr_nxt;
	logic [31:0]     rdata_nxt;
	logic            take;

	// clock generation: internal output clock toggles every div_r+1 cycles
	logic [7:0]      div_cnt_r;
	logic [7:0]      div_cnt_nxt;
	logic            oclk_r;
	logic            oclk_nxt;
	logic            rise;
	logic            fall;

	// power-down sampling and lock
	logic            pd_s;
	logic [1:0]      pd_cnt_r;
	logic [1:0]      pd_cnt_nxt;
	logic            pd_act_r;
	logic            pd_act_nxt;
	logic            running;

	// per-output gating
	logic [NOUT-1:0] oe_s;
	dco_ch_state_t   st_r   [NOUT];
	dco_ch_state_t   st_nxt [NOUT];
	logic [3:0]      cnt_r  [NOUT];
	logic [3:0]      cnt_nxt[NOUT];
	logic [NOUT-1:0] gate_r;
	logic [NOUT-1:0] gate_nxt;

	// zero wait states: write data follow their address by one cycle
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign take      = hsel && hready && (htrans == DCO_HTRANS_NONSEQ ||
	                   htrans == DCO_HTRANS_SEQ) && hsize == DCO_HSIZE_WORD;

	always_comb begin
		oe_reg_nxt  = oe_reg_r;
		div_nxt     = div_r;
		wr_pend_nxt = 1'b0;
		wr_addr_nxt = wr_addr_r;
		rdata_nxt   = hrdata;
		if (wr_pend_r) begin
			case (wr_addr_r)
				DCO_ADDR_OE: oe_reg_nxt = hwdata[NOUT-1:0];
				DCO_ADDR_DIV: div_nxt   = hwdata[7:0];
				default: ;
			endcase
		end
		if (take) begin
			wr_pend_nxt = hwrite;
			wr_addr_nxt = haddr[7:0];
			if (!hwrite) begin
				// next values forward a write still in its data phase
				case (haddr[7:0])
					DCO_ADDR_OE: rdata_nxt = {{(32-NOUT){1'b0}}, oe_reg_nxt};
					DCO_ADDR_STATUS: rdata_nxt = {{(30-NOUT){1'b0}}, pd_act_r, pll_locked, gate_r};
					DCO_ADDR_DIV: rdata_nxt = {24'h0, div_nxt};
					default: rdata_nxt = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			oe_reg_r  <= DCO_OE_RESET;
			div_r     <= DCO_DIV_RESET;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata    <= 32'h0;
		end else if (ce) begin
			oe_reg_r  <= oe_reg_nxt;
			div_r     <= div_nxt;
			wr_pend_r <= wr_pend_nxt;
			wr_addr_r <= wr_addr_nxt;
			hrdata    <= rdata_nxt;
		end
	end

	// output clock source
	always_comb begin
		rise        = 1'b0;
		fall        = 1'b0;
		div_cnt_nxt = div_cnt_r + 8'h01;
		oclk_nxt    = oclk_r;
		if (div_cnt_r >= div_r) begin
			div_cnt_nxt = 8'h00;
			oclk_nxt    = ~oclk_r;
			rise        = ~oclk_r;
			fall        = oclk_r;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt_r <= 8'h00;
			oclk_r    <= 1'b0;
		end else if (ce) begin
			div_cnt_r <= div_cnt_nxt;
			oclk_r    <= oclk_nxt;
		end
	end

	// power good resets low: reset state is powered down, so no false power-up
	dco_sync #(
		.WIDTH   (NOUT + 1),
		.RST_VAL ({1'b0, {NOUT{1'b1}}})
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.ce      (ce),
		.din     ({power_good_down, oe_n}),
		.dout    ({pd_s, oe_s})
	);

	// power-down: count rising-edge samples low, act from the next fall
	always_comb begin
		pd_cnt_nxt = pd_cnt_r;
		pd_act_nxt = pd_act_r;
		if (rise) begin
			if (!pd_s) begin
				pd_cnt_nxt = (pd_cnt_r == 2'(DCO_PD_SAMPLES)) ? pd_cnt_r : pd_cnt_r + 2'h1;
			end else begin
				pd_cnt_nxt = 2'h0;
			end
		end
		if (fall) begin
			pd_act_nxt = (pd_cnt_r == 2'(DCO_PD_SAMPLES));
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pd_cnt_r <= 2'(DCO_PD_SAMPLES);
			pd_act_r <= 1'b1;
		end else if (ce) begin
			pd_cnt_r <= pd_cnt_nxt;
			pd_act_r <= pd_act_nxt;
		end
	end

	// pll stops only once outputs are already forced low
	assign pll_run = ~pd_act_r;
	assign running = ~pd_act_r && pll_locked;

	// per-output state, advanced on rising edges, gate applied on falling edges
	always_comb begin
		for (int i = 0; i < NOUT; i++) begin
			st_nxt[i]  = st_r[i];
			cnt_nxt[i] = cnt_r[i];
			gate_nxt[i] = gate_r[i];
			if (!running) begin
				// forced low regardless of bit or pin
				st_nxt[i]   = DCO_CH_OFF;
				cnt_nxt[i]  = 4'h0;
				// not on a rise: the gate must not move while the clock goes high
				if (fall || (!oclk_r && !rise)) begin
					gate_nxt[i] = 1'b0;
				end
			end else if (rise) begin
				case (st_r[i])
					DCO_CH_OFF: begin
						if (oe_reg_r[i] && !oe_s[i]) begin
							st_nxt[i]  = DCO_CH_WAIT_ON;
							cnt_nxt[i] = 4'h1;
						end
					end
					// one period less than the floor here; the gate opens at the next fall, so
					// the first output rise comes the minimum after the first rise that saw the request
					DCO_CH_WAIT_ON: begin
						if (!(oe_reg_r[i] && !oe_s[i])) begin
							st_nxt[i] = DCO_CH_OFF;
						end else if (cnt_r[i] >= 4'(DCO_ON_MIN_PER - 1)) begin
							st_nxt[i] = DCO_CH_ON;
						end else begin
							cnt_nxt[i] = cnt_inc(cnt_r[i]);
						end
					end
					DCO_CH_ON: begin
						if (!(oe_reg_r[i] && !oe_s[i])) begin
							st_nxt[i]  = DCO_CH_DRAIN;
							cnt_nxt[i] = 4'h1;
						end
					end
					DCO_CH_DRAIN: begin
						if (cnt_r[i] >= 4'(DCO_OFF_KEEP_PER)) begin
							st_nxt[i] = DCO_CH_OFF;
						end else begin
							cnt_nxt[i] = cnt_inc(cnt_r[i]);
						end
					end
					default: st_nxt[i] = DCO_CH_OFF;
				endcase
			end
			if (running && fall) begin
				// gate updates only while the clock goes low; entering
				// power-down drops it at this same fall
				gate_nxt[i] = ((st_r[i] == DCO_CH_ON) || (st_r[i] == DCO_CH_DRAIN)) &&
				              !pd_act_nxt;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < NOUT; i++) begin
				st_r[i]  <= DCO_CH_OFF;
				cnt_r[i] <= 4'h0;
			end
			gate_r <= '0;
		end else if (ce) begin
			for (int i = 0; i < NOUT; i++) begin
				st_r[i]  <= st_nxt[i];
				cnt_r[i] <= cnt_nxt[i];
			end
			gate_r <= gate_nxt;
		end
	end

	// gated outputs; a disabled output is low on both legs
	always_comb begin
		diff_clock_out.p = gate_r & {NOUT{oclk_r}};
		diff_clock_out.n = gate_r & {NOUT{~oclk_r}};
	end
	assign feedback_clock_out = running & oclk_r;

	// checks: output 0 stands for all, the gating logic is the same per output
	a_gate_low_clk: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && $changed(gate_r) |-> !oclk_r)
		else $error("gate changed while clock high");

	a_off_both_low: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r[0] == DCO_CH_OFF && !oclk_r |-> !diff_clock_out.p[0] && !diff_clock_out.n[0])
		else $error("disabled output not low/low");

	a_needs_both: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(gate_r[0]) |-> oe_reg_r[0] && st_r[0] == DCO_CH_ON)
		else $error("output started without both enables");

	a_pd_forces_off: assert property (@(posedge hclk) disable iff (!hresetn)
		pd_act_r && !oclk_r |-> gate_r == '0)
		else $error("outputs active in power-down");

	a_pll_after_gate: assert property (@(posedge hclk) disable iff (!hresetn)
		$fell(pll_run) |-> gate_r == '0 || oclk_r)
		else $error("pll stopped with outputs live");

	a_no_lock_off: assert property (@(posedge hclk) disable iff (!hresetn)
		!pll_locked && !oclk_r |-> gate_r == '0)
		else $error("clock out without lock");

	a_drain_keep: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r[0] == DCO_CH_DRAIN && running |-> gate_r[0] || oclk_r)
		else $error("output stopped during drain");

	a_oe_write_lands: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && wr_pend_r && wr_addr_r == DCO_ADDR_OE |=> oe_reg_r == $past(hwdata[NOUT-1:0]))
		else $error("enable register write did not land");

	a_oe_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		ce && !(wr_pend_r && wr_addr_r == DCO_ADDR_OE) |=> $stable(oe_reg_r))
		else $error("enable register changed without a write");

	a_wait_dark: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r[0] == DCO_CH_WAIT_ON |-> !gate_r[0])
		else $error("output ran before the enable latency");

	a_drain_bound: assert property (@(posedge hclk) disable iff (!hresetn)
		st_r[0] == DCO_CH_DRAIN |-> cnt_r[0] <= 4'(DCO_OFF_KEEP_PER))
		else $error("drain ran past its period count");

	a_pd_two_rise: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(pd_act_r) |-> $past(pd_cnt_r) == 2'(DCO_PD_SAMPLES))
		else $error("power-down acted before two low samples");

	a_pd_legs_low: assert property (@(posedge hclk) disable iff (!hresetn)
		pd_act_r |-> diff_clock_out.p == '0 && diff_clock_out.n == '0)
		else $error("legs not low/low in power-down");
endmodule : dco_top
`default_nettype wire
